// File: shared/lurc_consts.vh
`ifndef LURC_CONSTS_VH
`define LURC_CONSTS_VH

// Timing figures and their cycle counts at the master clock rate.
`define LURC_CLK_PERIOD_NS   50
`define LURC_POR_TIME_US     1000
`define LURC_SWRST_TIME_NS   1000
`define LURC_POR_CYCLES      ((`LURC_POR_TIME_US * 1000) / `LURC_CLK_PERIOD_NS)
`define LURC_SWRST_CYCLES    (`LURC_SWRST_TIME_NS / `LURC_CLK_PERIOD_NS)

// Configuration write field selectors.
`define LURC_FLD_CHCFG       3'h0
`define LURC_FLD_TXTERM      3'h1
`define LURC_FLD_RXTERM      3'h2
`define LURC_FLD_SYSFMT      3'h3
`define LURC_FLD_INTMASK     3'h4
`define LURC_FLD_GPIODIR     3'h5
`define LURC_FLD_GLBRST      3'h6
`define LURC_FLD_HOSTDRV     3'h7

// Channel configuration bit positions.
`define LURC_CHCFG_MODE_BIT  0
`define LURC_CHCFG_RST_BIT   1

// Termination codes.
`define LURC_TERM_T1_100     3'h0
`define LURC_TERM_J1_110     3'h1
`define LURC_TERM_E1_120     3'h2
`define LURC_TERM_E1_75      3'h3

// Reset values.
`define LURC_MODE_RST        1'h0
`define LURC_SYSFMT_RST      1'h0
`define LURC_TERM_RST        3'h0
`define LURC_INTMASK_RST     8'hff
`define LURC_GPIODIR_RST     2'h0

`endif

// File: hw/lurc_reset_ctrl.v
// Summary of operation
// - Four reset sources: power-on, pin, global, channel.
// - Global resets clear everything; channel reset one channel.
// - Line pins high impedance during any reset.
// - Reset returns line mode to T1/J1.
// - Reset sets system side dual-rail NRZ.
// - Global reset makes host bus, GPIO inputs.
// - Resets clear state machines in their scope.
// - Resets mask interrupt sources in their scope.
// - Channel reset keeps line mode bit.
// - Power-on ends within 1 ms with clock.
// - Reset lasts while the pin is low.
// - Global reset register write, done within 1 us.
// - Channel reset bit self-clears within 1 us.
// - Channel reset leaves common logic, others alone.
// - Output and impedance pins act asynchronously.
// - Termination codes decode to four cable types.
// - Returning master clock triggers full reset.
`include "lurc_consts.vh"
`default_nettype none

module lurc_reset_ctrl #(
  parameter NUM_CH     = 16,
  parameter CH_W       = 4,
  parameter POR_CYCLES = `LURC_POR_CYCLES
) (
  input  wire                clk,
  input  wire                rst_n,
  input  wire                hwResetPin_n,
  input  wire                mclkPresent,
  input  wire                outputEnablePin,
  input  wire                rxImpedancePin,
  input  wire                cfgWr,
  input  wire [2:0]          cfgField,
  input  wire [CH_W-1:0]     cfgChan,
  input  wire [7:0]          cfgData,
  output wire                globalReset,
  output wire [NUM_CH-1:0]   chanReset,
  output wire [NUM_CH-1:0]   lineModeE1_ff,
  output wire [NUM_CH-1:0]   channelResetBit_ff,
  output wire [NUM_CH-1:0]   sysSingleRail_ff,
  output wire [8*NUM_CH-1:0] intMask_ff,
  output wire [3*NUM_CH-1:0] txTerm_ff,
  output wire [3*NUM_CH-1:0] rxTerm_ff,
  output wire [4*NUM_CH-1:0] txTermSel,
  output wire [4*NUM_CH-1:0] rxTermSel,
  output wire [NUM_CH-1:0]   txLineOe,
  output wire [NUM_CH-1:0]   rxLineEn,
  output reg                 hostBusOe_ff,
  output reg  [1:0]          gpioDir_ff
);

  localparam POR_W = 32;
  localparam SW_W  = 8;
  localparam [31:0]     SW_CYC32  = `LURC_SWRST_CYCLES;
  localparam [SW_W-1:0] SW_CYCLES = SW_CYC32[SW_W-1:0];
  // Channel reset stands SW_CYCLES cycles from the write edge.
  localparam [SW_W-1:0] CH_LAST   = SW_CYCLES - 8'h01;
  // Global release lands one cycle behind the counter, so stop a cycle early.
  localparam [SW_W-1:0] GSW_LAST  = SW_CYCLES - 8'h02;
  localparam [POR_W-1:0] POR_LAST = POR_CYCLES - 1;

  // One-hot cable type from a termination code: T1 100, J1 110, E1 120, E1 75.
  function [3:0] termDecode;
    input [2:0] code;
    begin
      case (code)
        `LURC_TERM_T1_100: termDecode = 4'h1;
        `LURC_TERM_J1_110: termDecode = 4'h2;
        `LURC_TERM_E1_120: termDecode = 4'h4;
        `LURC_TERM_E1_75:  termDecode = 4'h8;
        default:           termDecode = 4'h0;
      endcase
    end
  endfunction

  // Write strobe aimed at one configuration field.
  function fieldWr;
    input       wr;
    input [2:0] fld;
    input [2:0] want;
    begin
      fieldWr = wr && (fld == want);
    end
  endfunction

  // Three-stage synchronisers for the reset pin and the clock monitor.
  reg  [2:0]        hwSync_ff;
  reg  [2:0]        mclkSync_ff;
  reg               hwLow_ff;
  reg               mclkOk_ff;
  reg               porActive_ff;
  reg  [POR_W-1:0]  porCnt_ff;
  reg               gswActive_ff;
  reg  [SW_W-1:0]   gswCnt_ff;
  reg               gRst_ff;
  wire              gRstReq;
  wire              gswStart;

  always @(posedge clk) begin
    if (!rst_n) begin
      hwSync_ff <= 3'h7;
      hwLow_ff  <= 1'h0;
    end else begin
      hwSync_ff <= {hwSync_ff[1:0], hwResetPin_n};
      if (hwSync_ff[1] == hwSync_ff[2]) begin
        hwLow_ff <= ~hwSync_ff[2];
      end
    end
  end

  // Clock monitor synchroniser.
  always @(posedge clk) begin
    if (!rst_n) begin
      mclkSync_ff <= 3'h0;
      mclkOk_ff   <= 1'h0;
    end else begin
      mclkSync_ff <= {mclkSync_ff[1:0], mclkPresent};
      if (mclkSync_ff[1] == mclkSync_ff[2]) begin
        mclkOk_ff <= mclkSync_ff[2];
      end
    end
  end

  // Power-on reset: held without a master clock, restarted when it returns.
  always @(posedge clk) begin
    if (!rst_n) begin
      porActive_ff <= 1'h1;
      porCnt_ff    <= {POR_W{1'b0}};
    end else if (!mclkOk_ff) begin
      porActive_ff <= 1'h1;
      porCnt_ff    <= {POR_W{1'b0}};
    end else if (porActive_ff) begin
      if (porCnt_ff >= POR_LAST) begin
        porActive_ff <= 1'h0;
      end else begin
        porCnt_ff <= porCnt_ff + {{(POR_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Start of global software reset; refused while a global reset already runs.
  assign gswStart = fieldWr(cfgWr, cfgField, `LURC_FLD_GLBRST) && !gRst_ff;

  // Global software reset, any data value starts it.
  always @(posedge clk) begin
    if (!rst_n) begin
      gswActive_ff <= 1'h0;
      gswCnt_ff    <= {SW_W{1'b0}};
    end else if (gswStart) begin
      gswActive_ff <= 1'h1;
      gswCnt_ff    <= {SW_W{1'b0}};
    end else if (gswActive_ff) begin
      if (gswCnt_ff >= GSW_LAST) begin
        gswActive_ff <= 1'h0;
      end else begin
        gswCnt_ff <= gswCnt_ff + 8'h01;
      end
    end
  end

  // Any global source holds the merged request.
  assign gRstReq = porActive_ff | hwLow_ff | gswActive_ff;

  // All global reset sources merge into one register so release is on one edge.
  always @(posedge clk) begin
    if (!rst_n) begin
      gRst_ff <= 1'h1;
    end else begin
      gRst_ff <= gRstReq;
    end
  end

  // Global reset flag for all common logic.
  assign globalReset = gRst_ff;

  // Common host-side pins, untouched by channel resets.
  always @(posedge clk) begin
    if (!rst_n || gRst_ff) begin
      hostBusOe_ff <= 1'h0;
    end else if (fieldWr(cfgWr, cfgField, `LURC_FLD_HOSTDRV)) begin
      hostBusOe_ff <= cfgData[0];
    end
  end

  // General-purpose pin directions.
  always @(posedge clk) begin
    if (!rst_n || gRst_ff) begin
      gpioDir_ff <= `LURC_GPIODIR_RST;
    end else if (fieldWr(cfgWr, cfgField, `LURC_FLD_GPIODIR)) begin
      gpioDir_ff <= cfgData[1:0];
    end
  end

  // One slice of channel registers and line gating per channel.
  genvar i;
  generate
    for (i = 0; i < NUM_CH; i = i + 1) begin : gCh
      // Channel index as a constant of the select width.
      localparam [CH_W-1:0] CH_IDX = i;
      reg             chBit_ff;
      reg  [SW_W-1:0] chCnt_ff;
      reg             mode_ff;
      reg             sysFmt_ff;
      reg  [7:0]      mask_ff;
      reg  [2:0]      txCode_ff;
      reg  [2:0]      rxCode_ff;
      wire            chSel;
      wire            channel_reset_bit;
      wire            chStart;

      // Writes reach a channel only outside global reset and its own channel reset.
      assign chSel   = cfgWr && (cfgChan == CH_IDX) && !gRst_ff && !chBit_ff;
      assign chStart = chSel && (cfgField == `LURC_FLD_CHCFG) && cfgData[`LURC_CHCFG_RST_BIT];
      assign channel_reset_bit   = gRst_ff | chBit_ff;
      assign chanReset[i] = channel_reset_bit;

      // Channel reset bit reads high while the reset runs, then self-clears.
      always @(posedge clk) begin
        if (!rst_n || gRst_ff) begin
          chBit_ff <= 1'h0;
          chCnt_ff <= {SW_W{1'b0}};
        end else if (chStart) begin
          chBit_ff <= 1'h1;
          chCnt_ff <= {SW_W{1'b0}};
        end else if (chBit_ff) begin
          if (chCnt_ff >= CH_LAST) begin
            chBit_ff <= 1'h0;
          end else begin
            chCnt_ff <= chCnt_ff + 8'h01;
          end
        end
      end

      // Line mode is cleared only by global-class resets.
      always @(posedge clk) begin
        if (!rst_n || gRst_ff) begin
          mode_ff <= `LURC_MODE_RST;
        end else if (chSel && cfgField == `LURC_FLD_CHCFG) begin
          mode_ff <= cfgData[`LURC_CHCFG_MODE_BIT];
        end
      end

      // System side format returns to dual-rail on either reset scope.
      always @(posedge clk) begin
        if (!rst_n || channel_reset_bit) begin
          sysFmt_ff <= `LURC_SYSFMT_RST;
        end else if (chSel && cfgField == `LURC_FLD_SYSFMT) begin
          sysFmt_ff <= cfgData[0];
        end
      end

      // Interrupt masks are set on either reset scope.
      always @(posedge clk) begin
        if (!rst_n || channel_reset_bit) begin
          mask_ff <= `LURC_INTMASK_RST;
        end else if (chSel && cfgField == `LURC_FLD_INTMASK) begin
          mask_ff <= cfgData;
        end
      end

      // Termination codes return to defaults on either reset scope.
      always @(posedge clk) begin
        if (!rst_n || channel_reset_bit) begin
          txCode_ff <= `LURC_TERM_RST;
        end else if (chSel && cfgField == `LURC_FLD_TXTERM) begin
          txCode_ff <= cfgData[2:0];
        end
      end

      // Receive termination code.
      always @(posedge clk) begin
        if (!rst_n || channel_reset_bit) begin
          rxCode_ff <= `LURC_TERM_RST;
        end else if (chSel && cfgField == `LURC_FLD_RXTERM) begin
          rxCode_ff <= cfgData[2:0];
        end
      end

      // Register outputs, one driver per bit.
      assign channelResetBit_ff[i] = chBit_ff;
      assign lineModeE1_ff[i]      = mode_ff;
      assign sysSingleRail_ff[i]   = sysFmt_ff;
      assign intMask_ff[8*i +: 8]  = mask_ff;
      assign txTerm_ff[3*i +: 3]   = txCode_ff;
      assign rxTerm_ff[3*i +: 3]   = rxCode_ff;

      // Termination select per channel.
      assign txTermSel[4*i +: 4] = termDecode(txTerm_ff[3*i +: 3]);
      assign rxTermSel[4*i +: 4] = termDecode(rxTerm_ff[3*i +: 3]);

      // The pin controls reach the line drivers without passing any flip-flop.
      assign txLineOe[i] = outputEnablePin & ~channel_reset_bit;
      assign rxLineEn[i] = rxImpedancePin & ~channel_reset_bit;
    end
  endgenerate

endmodule // lurc_reset_ctrl

`default_nettype wire

// File: sim/lurc_host_model.sv
`default_nettype none
module lurc_host_model (
  input  wire logic clk,
  input  wire logic pulseReq,
  output var  logic hwResetPin_n
);
  timeunit 1ns;
  timeprecision 1ns;
  int lowCnt = 0;
  initial hwResetPin_n = 1'b1;
  // Holds the pin low for 30 cycles, longer than the 20 cycles of 1 us.
  always @(negedge clk) begin
    if (pulseReq) lowCnt = 30;
    else if (lowCnt > 0) lowCnt = lowCnt - 1;
    hwResetPin_n = (lowCnt == 0);
  end
endmodule // lurc_host_model
`default_nettype wire

// File: sim/lurc_props.sv
`default_nettype none
module lurc_props #(parameter int NUM_CH = 16) (
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic                hwResetPin_n,
  input wire logic                mclkPresent,
  input wire logic                outputEnablePin,
  input wire logic                rxImpedancePin,
  input wire logic                cfgWr,
  input wire logic [2:0]          cfgField,
  input wire logic                globalReset,
  input wire logic [NUM_CH-1:0]   chanReset,
  input wire logic [NUM_CH-1:0]   lineModeE1_ff,
  input wire logic [NUM_CH-1:0]   channelResetBit_ff,
  input wire logic [8*NUM_CH-1:0] intMask_ff,
  input wire logic [NUM_CH-1:0]   txLineOe,
  input wire logic [NUM_CH-1:0]   rxLineEn,
  input wire logic                hostBusOe_ff,
  input wire logic [1:0]          gpioDir_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  chk_line_hiz: assert property ((chanReset & (txLineOe | rxLineEn)) == '0)
    else $error("line pins driven in reset");
  chk_tx_gate: assert property (!outputEnablePin |-> txLineOe == '0)
    else $error("transmit not high impedance");
  chk_rx_gate: assert property (!rxImpedancePin |-> rxLineEn == '0)
    else $error("receive not high impedance");
  chk_glb_masks: assert property (globalReset && $past(globalReset) |-> intMask_ff == '1 && lineModeE1_ff == '0)
    else $error("defaults lost in global reset");
  chk_glb_pins: assert property ($past(globalReset) |-> !hostBusOe_ff && gpioDir_ff == 2'h0)
    else $error("host pins not inputs");
  chk_channel_reset_bit_len: assert property ($rose(|channelResetBit_ff) |-> (|channelResetBit_ff) [*8] ##[1:20] !(|channelResetBit_ff))
    else $error("channel reset length wrong");
  chk_gsw_len: assert property (cfgWr && cfgField == 3'h6 && !globalReset |-> ##2 globalReset ##[1:19] !globalReset)
    else $error("global soft reset length wrong");
  chk_keep_mode: assert property ((channelResetBit_ff & $past(channelResetBit_ff) & (lineModeE1_ff ^ $past(lineModeE1_ff))) == '0)
    else $error("mode changed in channel reset");
  chk_hw_hold: assert property (!hwResetPin_n [*6] |-> globalReset)
    else $error("pin reset not held");
  chk_clk_loss: assert property (!mclkPresent [*7] |-> globalReset)
    else $error("no reset without clock");
endmodule // lurc_props
bind lurc_reset_ctrl lurc_props #(.NUM_CH(NUM_CH)) i_props (.clk, .rst_n, .hwResetPin_n, .mclkPresent,
  .outputEnablePin, .rxImpedancePin, .cfgWr, .cfgField, .globalReset, .chanReset, .lineModeE1_ff,
  .channelResetBit_ff, .intMask_ff, .txLineOe, .rxLineEn, .hostBusOe_ff, .gpioDir_ff);
`default_nettype wire

// File: sim/test_line_unit_reset_control.sv
`default_nettype none
module test_line_unit_reset_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 0, rst_n = 0, mclkPresent = 1, outputEnablePin = 1, rxImpedancePin = 1;
  logic       cfgWr = 0, pulseReq = 0, hwResetPin_n, globalReset, hostBusOe_ff;
  logic [2:0] cfgField = 0;
  logic [1:0] cfgChan = 0, gpioDir_ff;
  logic [7:0] cfgData = 0, d, m[4];
  logic [3:0] chanReset, lineModeE1_ff, channelResetBit_ff, sysSingleRail_ff, txLineOe, rxLineEn;
  logic [31:0] intMask_ff;
  logic [11:0] txTerm_ff, rxTerm_ff;
  logic [15:0] txTermSel, rxTermSel;
  int bad_count = 0, compares = 0, cyc = 0;
  always #25 clk = ~clk;
  lurc_host_model i_host (.clk, .pulseReq, .hwResetPin_n);
  lurc_reset_ctrl #(.NUM_CH(4), .CH_W(2), .POR_CYCLES(50)) i_dut (.clk, .rst_n, .hwResetPin_n, .mclkPresent,
    .outputEnablePin, .rxImpedancePin, .cfgWr, .cfgField, .cfgChan, .cfgData, .globalReset, .chanReset,
    .lineModeE1_ff, .channelResetBit_ff, .sysSingleRail_ff, .intMask_ff, .txTerm_ff, .rxTerm_ff, .txTermSel,
    .rxTermSel, .txLineOe, .rxLineEn, .hostBusOe_ff, .gpioDir_ff);
  task automatic summarize();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] f, input logic [1:0] c, input logic [7:0] v);
    @(negedge clk);
    {cfgWr, cfgField, cfgChan, cfgData} = {1'b1, f, c, v};
    @(negedge clk);
    cfgWr = 0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
    do @(negedge clk); while (globalReset !== 1'b0);
  endtask
  task automatic dflt();
    chk(lineModeE1_ff, 0);
    chk(sysSingleRail_ff, 0);
    chk({hostBusOe_ff, gpioDir_ff}, 0);
    chk(intMask_ff, 32'hffffffff);
    chk({txTerm_ff, rxTerm_ff}, 0);
  endtask
  function automatic logic [3:0] sel(input logic [2:0] c);
    return c < 4 ? 4'h1 << c : 4'h0;
  endfunction
  initial begin
    void'($urandom(63435));
    repeat (16) @(negedge clk);
    rst_n = 1;
    settle(0);
    dflt();
    for (int k = 0; k < 8; k++) begin
      wr(3'h1, k[1:0], {5'h0, k[2:0]});
      chk(txTermSel[4*(k%4) +: 4], sel(k[2:0]));
    end
    wr(3'h1, 2'h3, 8'h03);
    chk(txTermSel[15:12], 4'h8);
    for (int c = 0; c < 4; c++) begin
      m[c] = $urandom;
      d = $urandom;
      wr(3'h0, c[1:0], 8'h01);
      wr(3'h3, c[1:0], 8'h01);
      wr(3'h4, c[1:0], m[c]);
      wr(3'h2, c[1:0], {5'h0, d[2:0]});
      chk(rxTermSel[4*c +: 4], sel(d[2:0]));
    end
    wr(3'h7, 2'h0, 8'h01);
    wr(3'h0, 2'h2, 8'h03);
    chk({txLineOe, rxLineEn}, 8'hbb);
    chk(chanReset, 4'h4);
    repeat (20) @(negedge clk);
    chk(channelResetBit_ff, 0);
    chk(lineModeE1_ff, 4'hf);
    chk(rxTerm_ff[8:6], 0);
    chk(sysSingleRail_ff, 4'hb);
    chk(intMask_ff, {m[3], 8'hff, m[1], m[0]});
    chk({txTerm_ff, hostBusOe_ff}, {3'h3, 3'h0, 3'h5, 3'h4, 1'b1});
    outputEnablePin = 0;
    rxImpedancePin = $urandom;
    #1 chk(txLineOe, 0);
    chk(rxLineEn, {4{rxImpedancePin}});
    outputEnablePin = 1;
    rxImpedancePin = 1;
    wr(3'h5, 2'h0, 8'h03);
    wr(3'h6, 2'h0, $urandom);
    settle(2);
    dflt();
    wr(3'h0, 2'h1, 8'h01);
    pulseReq <= 1;
    @(negedge clk) pulseReq <= 0;
    repeat (25) @(negedge clk);
    chk(globalReset, 1);
    settle(0);
    dflt();
    wr(3'h0, 2'h1, 8'h01);
    mclkPresent = 0;
    repeat (60) @(negedge clk);
    chk(globalReset, 1);
    mclkPresent = 1;
    settle(0);
    dflt();
    summarize();
  end
endmodule // test_line_unit_reset_control
`default_nettype wire
